// ---- design/ptmio_map.vh ----
// Register map, field positions, reset values and constants of the timer event block
`ifndef PTMIO_MAP_VH
`define PTMIO_MAP_VH

// Register indices; byte address is four times the index
`define PTMIO_IDX_PRESC01 16'hff14
`define PTMIO_IDX_PRESC23 16'hff15
`define PTMIO_IDX_SRCSEL 16'hff17
`define PTMIO_IDX_PRIO 16'hff21
`define PTMIO_IDX_IRQEN 16'hff25
`define PTMIO_IDX_FLAGS 16'hff29
`define PTMIO_IDX_WAVECTL 16'hff40
`define PTMIO_IDX_WAVESTAT 16'hff41

// Reset values
`define PTMIO_RST_PRESC 8'h00
`define PTMIO_RST_SRCSEL 5'h00
`define PTMIO_RST_PRIO 6'h00
`define PTMIO_RST_IRQEN 8'h00
`define PTMIO_RST_FLAGS 8'h00
`define PTMIO_RST_WAVECTL 6'h00

// Prescaler field: low timer in [3:0], high timer in [7:4]
`define PTMIO_PRESC_DIV_LSB 0
`define PTMIO_PRESC_GATE_BIT 3
`define PTMIO_PRESC_HALF 4

// Priority register: level fields and reserved read/write bits
`define PTMIO_PRIO_P01_LSB 2
`define PTMIO_PRIO_P23_LSB 4
`define PTMIO_PRIO_RSV_LSB 6

// Source select: one bit per timer, reserved read/write bit at D4
`define PTMIO_SRC_RSV_BIT 4

// Wave control: 16-bit mode bits, then pin enables
`define PTMIO_WCTL_MODE01_BIT 0
`define PTMIO_WCTL_MODE23_BIT 1
`define PTMIO_WCTL_PINEN_LSB 2

// Exception vectors: base and step between requests
`define PTMIO_VEC_BASE 24'h000016
`define PTMIO_VEC_STEP 24'h000002

// Serial interface divides the timer 1 underflow rate by this
`define PTMIO_SERIAL_DIV 32

`endif

// ---- design/ptmio_presc.v ----
// Per-timer prescaler: selects source, divides it, and gates the tick
`timescale 1ns/1ps
module ptmio_presc (
    input wire i_clk,
    input wire i_rst,
    input wire i_fast_tick,
    input wire i_slow_tick,
    input wire i_source_select,
    input wire [2:0] i_divider_field,
    input wire i_clock_gate,
    output reg o_tick
);

reg [11:0] cnt_q;
reg [11:0] term;
wire src_tick;

// Slow oscillator when the select bit is one, fast otherwise
assign src_tick = i_source_select ? i_slow_tick : i_fast_tick;

// Terminal count is the divide ratio minus one
always @* begin
    if (i_source_select) begin
        term = (12'h001 << i_divider_field) - 12'h001;
    end else begin
        case (i_divider_field)
            3'h0: term = 12'h000;
            3'h1: term = 12'h001;
            3'h2: term = 12'h007;
            3'h3: term = 12'h01f;
            3'h4: term = 12'h03f;
            3'h5: term = 12'h0ff;
            3'h6: term = 12'h3ff;
            default: term = 12'hfff;
        endcase
    end
end

// Count source edges; a ratio change mid-count may shorten one period
always @(posedge i_clk) begin
    if (i_rst) begin
        cnt_q <= 12'h000;
        o_tick <= 1'b0;
    end else begin
        o_tick <= 1'b0;
        if (src_tick) begin
            if (cnt_q >= term) begin
                cnt_q <= 12'h000;
                o_tick <= i_clock_gate;
            end else begin
                cnt_q <= cnt_q + 12'h001;
            end
        end
    end
end

endmodule

// ---- design/ptmio_top.v ----
// Timer event flags, interrupt requests, wave pins, baud tick and prescalers
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "ptmio_map.vh"
module ptmio_top (
    input wire i_clk,
    input wire i_rst,
    // APB slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [17:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [3:0] i_pstrb,
    output wire o_pready,
    output wire o_pslverr,
    output wire [31:0] o_prdata,
    // Events from the counter core, one-cycle pulses, then its reload and compare values
    input wire [3:0] i_underflow,
    input wire [3:0] i_match,
    input wire [1:0] i_pair_underflow,
    input wire [1:0] i_pair_match,
    input wire [31:0] i_reload_value,
    input wire [31:0] i_match_value,
    // Oscillator pins, asynchronous to i_clk
    input wire i_fast_oscillator,
    input wire i_slow_oscillator,
    // Port register settings for the two shared pins
    input wire [1:0] i_pin_direction_ctrl,
    input wire [1:0] i_pin_data_bit,
    output reg [1:0] o_pin_out,
    output reg [1:0] o_pin_oe,
    // Interrupt controller side
    output wire [7:0] o_irq_req,
    output wire [1:0] o_pair01_level,
    output wire [1:0] o_pair23_level,
    output reg [23:0] o_irq_vector,
    // Toward the counter core and serial interface
    output wire [3:0] o_timer_clk_tick,
    output wire o_serial_clk_tick,
    output wire [3:0] o_timer_wave_out
);

// ****************************************************************
// Registers and APB decode
// ****************************************************************

reg [7:0] presc01_q;
reg [7:0] presc23_q;
reg [4:0] srcsel_q;
reg [5:0] prio_q;
reg [7:0] irq_en_q;
reg [7:0] flags_q;
reg [7:0] flags_d;
reg [5:0] wavectl_q;
reg [31:0] prdata_q;
reg [31:0] rd_mux;
reg rd_hit;
reg [3:0] wave_q;
reg [3:0] wave_d;
reg [3:0] uf_dly_q;
reg [3:0] mt_dly_q;
reg [3:0] eff_uf;
reg [3:0] eff_mt;
reg [3:0] fix_one;

wire [15:0] acc_idx;
wire acc_word;
wire setup_ph;
wire wr_en;
wire [7:0] wbyte;
wire [1:0] mode16;
wire [3:0] pin_en;
wire [7:0] presc_all;
wire [15:0] presc_pair;
wire [7:0] ev_set;
wire [7:0] w1c_mask;

assign acc_idx = i_paddr[17:2];
assign acc_word = (i_paddr[1:0] == 2'b00);
assign setup_ph = i_psel & ~i_penable;
assign wr_en = i_psel & i_penable & i_pwrite & i_pstrb[0];
assign wbyte = i_pwdata[7:0];
assign mode16 = {wavectl_q[`PTMIO_WCTL_MODE23_BIT],
                 wavectl_q[`PTMIO_WCTL_MODE01_BIT]};
assign pin_en = wavectl_q[`PTMIO_WCTL_PINEN_LSB +: 4];
assign presc_pair = {presc23_q, presc01_q};

// Zero-wait slave: every access completes in its first access cycle
assign o_pready = 1'b1;
assign o_pslverr = i_psel & i_penable & ~rd_hit;
assign o_prdata = prdata_q;

// Read mux and address hit, decoded from the live address
always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = acc_word;
    if (acc_idx == `PTMIO_IDX_PRESC01) begin
        rd_mux[7:0] = presc01_q;
    end else if (acc_idx == `PTMIO_IDX_PRESC23) begin
        rd_mux[7:0] = presc23_q;
    end else if (acc_idx == `PTMIO_IDX_SRCSEL) begin
        rd_mux[4:0] = srcsel_q;
    end else if (acc_idx == `PTMIO_IDX_PRIO) begin
        rd_mux[7:2] = prio_q;
    end else if (acc_idx == `PTMIO_IDX_IRQEN) begin
        rd_mux[7:0] = irq_en_q;
    end else if (acc_idx == `PTMIO_IDX_FLAGS) begin
        rd_mux[7:0] = flags_q;
    end else if (acc_idx == `PTMIO_IDX_WAVECTL) begin
        rd_mux[5:0] = wavectl_q;
    end else if (acc_idx == `PTMIO_IDX_WAVESTAT) begin
        rd_mux[3:0] = wave_q;
        rd_mux[5:4] = o_pin_out;
    end else begin
        rd_hit = 1'b0;
    end
end

// Read data is captured in the setup cycle so it is ready at access
always @(posedge i_clk) begin
    if (i_rst) begin
        prdata_q <= 32'h0000_0000;
    end else if (setup_ph && !i_pwrite) begin
        prdata_q <= rd_mux;
    end
end

// Plain read/write control registers
always @(posedge i_clk) begin
    if (i_rst) begin
        presc01_q <= `PTMIO_RST_PRESC;
        presc23_q <= `PTMIO_RST_PRESC;
        srcsel_q <= `PTMIO_RST_SRCSEL;
        prio_q <= `PTMIO_RST_PRIO;
        irq_en_q <= `PTMIO_RST_IRQEN;
        wavectl_q <= `PTMIO_RST_WAVECTL;
    end else if (wr_en && acc_word) begin
        if (acc_idx == `PTMIO_IDX_PRESC01) begin
            presc01_q <= wbyte;
        end else if (acc_idx == `PTMIO_IDX_PRESC23) begin
            presc23_q <= wbyte;
        end else if (acc_idx == `PTMIO_IDX_SRCSEL) begin
            srcsel_q <= wbyte[4:0];
        end else if (acc_idx == `PTMIO_IDX_PRIO) begin
            prio_q <= wbyte[7:2];
        end else if (acc_idx == `PTMIO_IDX_IRQEN) begin
            irq_en_q <= wbyte;
        end else if (acc_idx == `PTMIO_IDX_WAVECTL) begin
            wavectl_q <= wbyte[5:0];
        end
    end
end

// ****************************************************************
// Event selection per pair
// ****************************************************************

// Lower timer is silent in 16-bit mode; upper takes the 16-bit events
always @* begin
    eff_uf = i_underflow;
    eff_mt = i_match;
    if (mode16[0]) begin
        eff_uf[0] = 1'b0;
        eff_mt[0] = 1'b0;
        eff_uf[1] = i_pair_underflow[0];
        eff_mt[1] = i_pair_match[0];
    end
    if (mode16[1]) begin
        eff_uf[2] = 1'b0;
        eff_mt[2] = 1'b0;
        eff_uf[3] = i_pair_underflow[1];
        eff_mt[3] = i_pair_match[1];
    end
end

// Flag bit order: underflow then match for each timer
assign ev_set = {eff_mt[3], eff_uf[3], eff_mt[2], eff_uf[2],
                 eff_mt[1], eff_uf[1], eff_mt[0], eff_uf[0]};

// ****************************************************************
// Cause flags and requests
// ****************************************************************

assign w1c_mask = (wr_en && acc_word && acc_idx == `PTMIO_IDX_FLAGS)
                  ? wbyte : 8'h00;

// Set beats clear so an event in the clearing cycle is not lost
always @* begin
    flags_d = (flags_q & ~w1c_mask) | ev_set;
end

always @(posedge i_clk) begin
    if (i_rst) begin
        flags_q <= `PTMIO_RST_FLAGS;
    end else begin
        flags_q <= flags_d;
    end
end

// Enable masks the request only; the flag keeps the record
assign o_irq_req = flags_q & irq_en_q;
assign o_pair01_level = prio_q[`PTMIO_PRIO_P01_LSB - 2 +: 2];
assign o_pair23_level = prio_q[`PTMIO_PRIO_P23_LSB - 2 +: 2];

// Vector of the lowest-numbered pending request
always @(posedge i_clk) begin : vec_blk
    integer k;
    if (i_rst) begin
        o_irq_vector <= `PTMIO_VEC_BASE;
    end else begin
        o_irq_vector <= `PTMIO_VEC_BASE;
        for (k = 7; k >= 0; k = k - 1) begin
            if (o_irq_req[k]) begin
                o_irq_vector <= `PTMIO_VEC_BASE
                    + `PTMIO_VEC_STEP * k[23:0];
            end
        end
    end
end

// ****************************************************************
// Wave generation and pins
// ****************************************************************

// Reload not above compare pins the wave high; 16-bit pairs compare wide
always @* begin
    fix_one[0] = i_reload_value[7:0] <= i_match_value[7:0];
    fix_one[2] = i_reload_value[23:16] <= i_match_value[23:16];
    fix_one[1] = mode16[0]
        ? (i_reload_value[15:0] <= i_match_value[15:0])
        : (i_reload_value[15:8] <= i_match_value[15:8]);
    fix_one[3] = mode16[1]
        ? (i_reload_value[31:16] <= i_match_value[31:16])
        : (i_reload_value[31:24] <= i_match_value[31:24]);
end

// Falling edge of each event pulse moves the wave
always @* begin : wave_blk
    integer t;
    t = 0;
    wave_d = wave_q;
    for (t = 0; t < 4; t = t + 1) begin
        if (fix_one[t]) begin
            wave_d[t] = 1'b1;
        end else if (uf_dly_q[t] && !eff_uf[t]) begin
            wave_d[t] = 1'b1;
        end else if (mt_dly_q[t] && !eff_mt[t]) begin
            wave_d[t] = 1'b0;
        end
    end
end

always @(posedge i_clk) begin
    if (i_rst) begin
        wave_q <= 4'h0;
        uf_dly_q <= 4'h0;
        mt_dly_q <= 4'h0;
    end else begin
        wave_q <= wave_d;
        uf_dly_q <= eff_uf;
        mt_dly_q <= eff_mt;
    end
end

assign o_timer_wave_out = wave_q;

// Pin mux; enable acts directly, so switching may cut a half cycle
always @* begin : pin_blk
    integer p;
    p = 0;
    for (p = 0; p < 2; p = p + 1) begin
        if (pin_en[2 * p + 1]) begin
            o_pin_out[p] = wave_q[2 * p + 1];
            o_pin_oe[p] = 1'b1;
        end else if (pin_en[2 * p] && !mode16[p]) begin
            o_pin_out[p] = wave_q[2 * p];
            o_pin_oe[p] = 1'b1;
        end else begin
            o_pin_out[p] = i_pin_data_bit[p];
            o_pin_oe[p] = i_pin_direction_ctrl[p];
        end
    end
end

// Timer 1 underflow alone feeds the serial divider by 32
assign o_serial_clk_tick = eff_uf[1];

// ****************************************************************
// Oscillator sampling and prescalers
// ****************************************************************

reg [1:0] fast_sync_q;
reg [1:0] slow_sync_q;
reg fast_last_q;
reg slow_last_q;
wire fast_tick;
wire slow_tick;

// Two flops before use; oscillators must run below half of i_clk
always @(posedge i_clk) begin
    if (i_rst) begin
        fast_sync_q <= 2'b00;
        slow_sync_q <= 2'b00;
        fast_last_q <= 1'b0;
        slow_last_q <= 1'b0;
    end else begin
        fast_sync_q <= {fast_sync_q[0], i_fast_oscillator};
        slow_sync_q <= {slow_sync_q[0], i_slow_oscillator};
        fast_last_q <= fast_sync_q[1];
        slow_last_q <= slow_sync_q[1];
    end
end

assign fast_tick = fast_sync_q[1] & ~fast_last_q;
assign slow_tick = slow_sync_q[1] & ~slow_last_q;

genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : g_presc
        ptmio_presc u_presc (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_fast_tick(fast_tick),
            .i_slow_tick(slow_tick),
            .i_source_select(srcsel_q[g]),
            .i_divider_field(presc_pair[g * 4 +: 3]),
            .i_clock_gate(presc_pair[g * 4 + 3]),
            .o_tick(o_timer_clk_tick[g])
        );
    end
endgenerate

endmodule

// ---- verif/ptmio_serial_model.sv ----
// Serial interface model that counts bit clocks from the timer 1 tick
`timescale 1ns/1ps
module ptmio_serial_model (
    input wire i_clk,
    input wire i_rst,
    input wire i_tick,
    output reg [7:0] o_bits
);
    reg [4:0] div_q;
    // One bit clock per 32 ticks; the compare value never reaches here
    always @(posedge i_clk) begin
        if (i_rst) begin
            div_q <= 5'h00;
            o_bits <= 8'h00;
        end else if (i_tick) begin
            div_q <= div_q + 5'h01;
            if (div_q == 5'h1f) begin
                o_bits <= o_bits + 8'h01;
            end
        end
    end
endmodule

// ---- verif/ptmio_properties.sv ----
// Port checker for the timer event block
`timescale 1ns/1ps
module ptmio_props (
    input wire i_clk,
    input wire i_rst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire o_pready,
    input wire [3:0] i_underflow,
    input wire [3:0] i_match,
    input wire [1:0] i_pair_underflow,
    input wire [1:0] i_pair_match,
    input wire [31:0] i_reload_value,
    input wire [31:0] i_match_value,
    input wire [1:0] i_pin_direction_ctrl,
    input wire [1:0] i_pin_data_bit,
    input wire [1:0] o_pin_out,
    input wire [1:0] o_pin_oe,
    input wire [7:0] o_irq_req,
    input wire [23:0] o_irq_vector,
    input wire o_serial_clk_tick,
    input wire [3:0] o_timer_wave_out
);
    // ********************************
    // Event map and expected vector
    // ********************************
    wire [7:0] ev;
    wire wr = i_psel && i_penable && i_pwrite;
    // Pair events land on the upper timer's request bits
    assign ev = {i_match[3], i_underflow[3], i_match[2], i_underflow[2],
                 i_match[1], i_underflow[1], i_match[0], i_underflow[0]}
              | {i_pair_match[1], i_pair_underflow[1], 2'b00,
                 i_pair_match[0], i_pair_underflow[0], 2'b00};
    // Lowest pending request wins; idle shows the first vector
    function [23:0] exp_vec(input [7:0] r);
        integer k;
        begin
            exp_vec = 24'h000016;
            for (k = 7; k >= 0; k = k - 1) begin
                if (r[k]) exp_vec = 24'h000016 + {k[22:0], 1'b0};
            end
        end
    endfunction
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence uf0_end;
        i_underflow[0] ##1 (!i_underflow[0] && !i_match[0]);
    endsequence
    sequence m0_end;
        i_match[0] ##1 (!i_match[0] && !i_underflow[0]
            && i_reload_value[7:0] > i_match_value[7:0]);
    endsequence
    req_rise_cause_a: assert property (
        (o_irq_req & ~$past(o_irq_req) & ~$past(ev)) != 8'h00 |-> $past(wr))
        else $error("request rose with no cause");
    req_fall_write_a: assert property (
        (~o_irq_req & $past(o_irq_req)) != 8'h00 |-> $past(wr))
        else $error("request fell with no write");
    vector_order_a: assert property (
        o_irq_vector == exp_vec($past(o_irq_req)))
        else $error("vector wrong");
    wave_rise_a: assert property (uf0_end |=> o_timer_wave_out[0])
        else $error("wave did not rise");
    wave_fall_a: assert property (m0_end |=> !o_timer_wave_out[0])
        else $error("wave did not fall");
    // Release edge excluded: the wave is still zero one edge after reset
    wave_forced_a: assert property (
        !i_rst && i_reload_value[7:0] <= i_match_value[7:0]
        |=> o_timer_wave_out[0])
        else $error("wave not held high");
    // Without a waveform the pin shows the port data bit
    pin_port_a: assert property (
        !o_pin_oe[0] |-> o_pin_out[0] == i_pin_data_bit[0])
        else $error("pin not from port data");
    pin_drive_a: assert property (
        o_pin_oe[0] != i_pin_direction_ctrl[0] |-> o_pin_oe[0]
        && (o_pin_out[0] == o_timer_wave_out[0]
        || o_pin_out[0] == o_timer_wave_out[1]))
        else $error("pin not from wave");
    serial_src_a: assert property (
        o_serial_clk_tick |-> i_underflow[1] || i_pair_underflow[0])
        else $error("serial tick with no underflow");
    apb_ready_a: assert property (i_psel && i_penable |-> o_pready)
        else $error("access not answered");
endmodule
bind ptmio_top ptmio_props u_props (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .o_pready(o_pready), .i_underflow(i_underflow),
    .i_match(i_match), .i_pair_underflow(i_pair_underflow),
    .i_pair_match(i_pair_match), .i_reload_value(i_reload_value),
    .i_match_value(i_match_value), .o_pin_out(o_pin_out),
    .i_pin_direction_ctrl(i_pin_direction_ctrl), .o_pin_oe(o_pin_oe),
    .i_pin_data_bit(i_pin_data_bit), .o_irq_req(o_irq_req),
    .o_irq_vector(o_irq_vector), .o_serial_clk_tick(o_serial_clk_tick),
    .o_timer_wave_out(o_timer_wave_out)
);

// ---- verif/tb_top.sv ----
// Self-checking bench for the timer event block
`timescale 1ns/1ps
module tb_top;
    logic clk, rst, psel, pen, pwr, fo, so, rdy, err, stk, erv;
    logic [17:0] addr;
    logic [31:0] wd, rl, cm, rdata, rdv;
    logic [3:0] uf, mt, tck, wav;
    logic [1:0] puf, pmt, dir, dat, pin, oe, l01, l23;
    logic [7:0] req, bits;
    logic [23:0] vec;
    logic [15:0] ixs [6] = '{16'hff14, 16'hff15, 16'hff17, 16'hff21,
                             16'hff25, 16'hff29};
    logic [7:0] pv [4] = '{8'h00, 8'h24, 8'h18, 8'hff};
    int n_mismatch = 0;
    int n_checks = 0;
    int ticks = 0;
    int t0;
    ptmio_top dut (
        .i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .i_pstrb(4'h1),
        .o_pready(rdy), .o_pslverr(err), .o_prdata(rdata),
        .i_underflow(uf), .i_match(mt), .i_pair_underflow(puf),
        .i_pair_match(pmt), .i_reload_value(rl), .i_match_value(cm),
        .i_fast_oscillator(fo), .i_slow_oscillator(so),
        .i_pin_direction_ctrl(dir), .i_pin_data_bit(dat), .o_pin_out(pin),
        .o_pin_oe(oe), .o_irq_req(req), .o_pair01_level(l01),
        .o_pair23_level(l23), .o_irq_vector(vec), .o_timer_clk_tick(tck),
        .o_serial_clk_tick(stk), .o_timer_wave_out(wav)
    );
    ptmio_serial_model sm (.i_clk(clk), .i_rst(rst), .i_tick(stk),
        .o_bits(bits));
    // ********************************
    // Clock, tick counter and tasks
    // ********************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Timer 0 prescaled ticks
    always @(posedge clk) begin
        if (tck[0] === 1'b1) ticks <= ticks + 1;
    end
    task automatic summarize();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One transfer; u rides on the access cycle as an underflow event
    task automatic apb(input logic w, input logic [15:0] ix,
                       input logic [7:0] d, input logic [3:0] u);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= {ix, 2'b00};
        wd <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        uf <= u;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        // A missing answer ends the run; nothing follows the verdict
        if (rdy !== 1'b1) begin
            n_mismatch++;
            summarize();
        end else begin
            rdv = rdata;
            erv = err;
            psel <= 1'b0;
            pen <= 1'b0;
            uf <= 4'h0;
        end
    endtask
    task automatic rdchk(input logic [15:0] ix, input logic [31:0] e,
                         input string nm);
        apb(1'b0, ix, 8'h00, 4'h0);
        chk(nm, e, rdv);
    endtask
    // Event bits in request order; p holds pair underflow, pair match
    task automatic pulse(input logic [7:0] e, input logic [3:0] p);
        @(posedge clk);
        uf <= {e[6], e[4], e[2], e[0]};
        mt <= {e[7], e[5], e[3], e[1]};
        {pmt, puf} <= p;
        @(posedge clk);
        {uf, mt, pmt, puf} <= 12'h000;
    endtask
    // Oscillators run well below half the bus clock for the synchronisers
    task automatic osc(input logic s, input int n);
        repeat (n) begin
            cyc(2);
            if (s) so <= 1'b1;
            else fo <= 1'b1;
            cyc(2);
            {so, fo} <= 2'b00;
        end
        cyc(8);
    endtask
    // ********************************
    // Scenarios
    // ********************************
    initial begin
        {psel, pen, pwr, fo, so} = 5'h00;
        {uf, mt, puf, pmt} = 12'h000;
        {addr, wd} = 50'h0;
        rl = 32'h10101010;
        cm = 32'h08080808;
        {dir, dat} = 4'ha;
        rst = 1'b1;
        cyc(3);
        rst <= 1'b0;
        foreach (ixs[i]) rdchk(ixs[i], 32'h0, "reset value");
        rdchk(16'h0000, 32'h0, "unmapped data");
        chk("unmapped error", 32'h1, {31'h0, erv});
        foreach (pv[i]) begin
            apb(1'b1, 16'hff21, pv[i], 4'h0);
            cyc(1);
            chk("level01", {30'h0, pv[i][3:2]}, {30'h0, l01});
            chk("level23", {30'h0, pv[i][5:4]}, {30'h0, l23});
            rdchk(16'hff21, {24'h0, pv[i] & 8'hfc}, "priority");
        end
        apb(1'b1, 16'hff25, 8'hff, 4'h0);
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i, 4'h0);
            cyc(2);
            chk("request", 32'h1 << i, {24'h0, req});
            chk("vector", 32'h16 + 2 * i, {8'h0, vec});
            apb(1'b1, 16'hff29, 8'h01 << i, 4'h0);
            cyc(1);
            chk("cleared", 32'h0, {24'h0, req});
        end
        chk("wave idle", 32'h0, {28'h0, wav});
        chk("port pins", 32'ha, {28'h0, oe, pin});
        pulse(8'h01, 4'h0);
        cyc(2);
        chk("wave up", 32'h1, {28'h0, wav});
        apb(1'b1, 16'hff40, 8'h04, 4'h0);
        cyc(1);
        chk("pin t0", 32'hf, {28'h0, oe, pin});
        apb(1'b1, 16'hff40, 8'h0c, 4'h0);
        cyc(1);
        chk("pin t1 wins", 32'he, {28'h0, oe, pin});
        apb(1'b1, 16'hff40, 8'h05, 4'h0);
        cyc(1);
        chk("pin lower off", 32'ha, {28'h0, oe, pin});
        apb(1'b1, 16'hff40, 8'h09, 4'h0);
        pulse(8'h00, 4'h1);
        cyc(2);
        chk("pin pair wave", 32'hf, {28'h0, oe, pin});
        apb(1'b1, 16'hff40, 8'h00, 4'h0);
        cm <= 32'h08080810;
        pulse(8'h02, 4'h0);
        cyc(2);
        chk("forced high", 32'h1, {31'h0, wav[0]});
        apb(1'b1, 16'hff40, 8'h03, 4'h0);
        apb(1'b1, 16'hff29, 8'hff, 4'h0);
        pulse(8'h0f, 4'hf);
        rdchk(16'hff29, 32'hcc, "pair flags");
        apb(1'b1, 16'hff40, 8'h00, 4'h0);
        apb(1'b1, 16'hff29, 8'hff, 4'h0);
        apb(1'b1, 16'hff25, 8'h00, 4'h0);
        pulse(8'h01, 4'h0);
        cyc(1);
        chk("masked", 32'h0, {24'h0, req});
        rdchk(16'hff29, 32'h1, "kept flag");
        apb(1'b1, 16'hff29, 8'h00, 4'h0);
        rdchk(16'hff29, 32'h1, "zero write");
        apb(1'b1, 16'hff29, 8'h01, 4'h1);
        rdchk(16'hff29, 32'h1, "event wins");
        apb(1'b1, 16'hff25, 8'h01, 4'h0);
        cyc(1);
        chk("unmasked", 32'h1, {24'h0, req});
        apb(1'b1, 16'hff29, 8'h01, 4'h0);
        rdchk(16'hff29, 32'h0, "one clears");
        rst <= 1'b1;
        cyc(3);
        rst <= 1'b0;
        repeat (31) pulse(8'h04, 4'h0);
        pulse(8'h08, 4'h0);
        chk("serial early", 32'h0, {24'h0, bits});
        pulse(8'h04, 4'h0);
        cyc(1);
        chk("serial bit", 32'h1, {24'h0, bits});
        apb(1'b1, 16'hff17, 8'hff, 4'h0);
        rdchk(16'hff17, 32'h1f, "source");
        apb(1'b1, 16'hff17, 8'h01, 4'h0);
        apb(1'b1, 16'hff14, 8'h0a, 4'h0);
        rdchk(16'hff14, 32'h0a, "divider");
        t0 = ticks;
        osc(1'b1, 16);
        chk("slow ticks", 32'd4, ticks - t0);
        apb(1'b1, 16'hff17, 8'h00, 4'h0);
        t0 = ticks;
        osc(1'b0, 16);
        chk("fast ticks", 32'd2, ticks - t0);
        apb(1'b1, 16'hff14, 8'h02, 4'h0);
        t0 = ticks;
        osc(1'b0, 16);
        chk("gated ticks", 32'd0, ticks - t0);
        summarize();
    end
endmodule
